//--- rtl/timer_defines.svh
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// Register addresses on the CPU data space
`define A_TMC1 16'hFF43
`define A_TMC0 16'hFF6B
`define A_TCL1 16'hFF8C
`define A_TCL0 16'hFF8B
`define A_CNT0 16'hFF16
`define A_CNT1 16'hFF1F
`define A_CMP0 16'hFF17
`define A_CMP1 16'hFF41

// Mode-control bit positions
`define RUN_BIT  7
`define MODE_BIT 6
`define PSET_HI  3
`define PSET_LO  2
`define INV_BIT  1
`define GATE_BIT 0

// Stored and readable bits of the mode-control register
`define TMC_KEEP 8'hC3
`define PSET_NONE 2'h0
`define PSET_ZERO 2'h1
`define PSET_ONE  2'h2

// Count-clock codes
`define CS_FALL 3'h0
`define CS_RISE 3'h1
`define CS_FX   3'h2
`define CS_FX2  3'h3
`define CS_TA   3'h4
`define CS_TB   3'h5
`define CS_TC   3'h6
`define CS_TD   3'h7

// Prescaler tap exponents per channel
`define TAP0_A 2
`define TAP0_B 6
`define TAP0_C 8
`define TAP0_D 13
`define TAP1_A 4
`define TAP1_B 6
`define TAP1_C 8
`define TAP1_D 12

// Prescaler counter width and tap count
`define PRE_W  13
`define TAP_N  14

// Reset values and limits
`define TMC_RST   8'h00
`define TCL_RST   3'h0
`define CNT_RST   8'h00
`define CMP_RST   8'h00
`define CNT_MAX   8'hFF
`define BYTE_ZERO 8'h00
`define NCH       2

`endif

//--- rtl/timer_pkg.sv
`include "timer_defines.svh"

package timer_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] addr_t;
  typedef logic [2:0]  bsel_t;
  typedef logic [`NCH-1:0] chan_t;

  typedef struct packed {
    logic [`PRE_W-1:0] cnt;
  } presc_s;

  typedef struct packed {
    chan_t prev;
    chan_t rise;
    chan_t fall;
  } edge_s;

  typedef struct packed {
    logic [`NCH-1:0][2:0] tcl;
    logic [`NCH-1:0][7:0] tmc;
    logic [`NCH-1:0][7:0] cnt;
    logic [`NCH-1:0][7:0] cmp;
    chan_t                outff;
    chan_t                pwmff;
    chan_t                pin;
    chan_t                irq;
    byte_t                rdata;
    logic                 rd_ack;
  } core_s;

endpackage : timer_pkg

//--- rtl/timer_taps_if.sv
`timescale 1ns/1ps
`include "timer_defines.svh"

interface timer_taps_if;
  logic [`TAP_N-1:0] tick;
  logic [`NCH-1:0]   ev_rise;
  logic [`NCH-1:0]   ev_fall;

  modport presc    (output tick);
  modport edge_det (output ev_rise, output ev_fall);
  modport core     (input tick, input ev_rise, input ev_fall);
endinterface : timer_taps_if

//--- rtl/count_prescaler.sv
`timescale 1ns/1ps
`include "timer_defines.svh"

module count_prescaler (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Tap pulses
  timer_taps_if.presc taps
);
  import timer_pkg::*;

  presc_s s_q;
  presc_s s_d;

  always_comb begin
    s_d     = s_q;
    s_d.cnt = s_q.cnt + `PRE_W'(1);
  end

  // Tap k pulses once every 2^k cycles of the main clock
  always_comb begin
    taps.tick[0] = 1'b1;
    for (int k = 1; k < `TAP_N; k++) begin
      taps.tick[k] = (s_q.cnt & ((`PRE_W'(1) << k) - `PRE_W'(1))) ==
                     ((`PRE_W'(1) << k) - `PRE_W'(1));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : count_prescaler

//--- rtl/event_edge_detect.sv
`timescale 1ns/1ps

module event_edge_detect (
  // Clock and reset
  input wire logic           clk_sys,
  input wire logic           sys_rst,
  // Event input pins
  input wire timer_pkg::chan_t event_input_pin,
  // Edge pulses
  timer_taps_if.edge_det     taps
);
  import timer_pkg::*;

  edge_s s_q;
  edge_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.prev = event_input_pin;
    s_d.rise = event_input_pin & ~s_q.prev;
    s_d.fall = ~event_input_pin & s_q.prev;
  end

  assign taps.ev_rise = s_q.rise;
  assign taps.ev_fall = s_q.fall;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : event_edge_detect

//--- rtl/eight_bit_timer_control_regs.sv
// How it works
// - Codes 000..011 pick event falling, event rising, main clock, main clock/2.
// - Channel 0 codes 100..111 pick main clock over 4, 64, 256, 8192.
// - Channel 1 codes 100..111 pick main clock over 16, 64, 256, 4096.
// - Reset clears both clock-select registers, choosing event falling edge.
// - Clock-select registers take only byte writes; bit writes are ignored.
// - Run bit set counts; cleared it zeroes and holds the counter.
// - Mode bit: 0 clear on compare match, 1 free-running PWM.
// - Preset bits 3:2 written 01 clear, 10 set the output flip-flop.
// - Bit 1 enables toggling outside PWM, picks active-low in PWM.
// - Bit 0 gates the output pin; cleared the pin stays low.
// - Preset bits are write-only and read back as zero.
// - Presets act only when the channel is not in PWM mode.
// - In PWM mode a cleared run bit makes the output inactive.
// - Mode, preset, level and gate bits reach the pin regardless of run.
// - Counter steps on each selected count tick and is read-only.
// - Outside PWM, a counter match with compare raises the match request.
// - In PWM, overflow makes output active, compare match makes it inactive.
`timescale 1ns/1ps
`include "timer_defines.svh"

module eight_bit_timer_control_regs (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // CPU register access
  input  wire timer_pkg::addr_t  cpu_addr,
  input  wire logic              cpu_wr,
  input  wire timer_pkg::byte_t  cpu_wdata,
  input  wire logic              cpu_bit_wr,
  input  wire timer_pkg::bsel_t  cpu_bit_sel,
  input  wire logic              cpu_bit_val,
  input  wire logic              cpu_rd,
  output timer_pkg::byte_t       cpu_rdata,
  output logic                   cpu_rd_ack,
  // Board pins
  input  wire timer_pkg::chan_t  event_input_pin,
  output timer_pkg::chan_t       timer_output_pin,
  // Match interrupt requests
  output timer_pkg::chan_t       match_irq
);
  import timer_pkg::*;

  timer_taps_if taps ();

  count_prescaler u_presc (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .taps    (taps)
  );

  event_edge_detect u_edge (
    .clk_sys         (clk_sys),
    .sys_rst         (sys_rst),
    .event_input_pin (event_input_pin),
    .taps            (taps)
  );

  core_s s_q;
  core_s s_d;

  // Picks the count enable for one channel from its clock code
  function automatic logic sel_tick(
    input logic              ch,
    input logic [2:0]        code,
    input logic [`TAP_N-1:0] t,
    input logic              rise,
    input logic              fall
  );
    logic r;
    r = 1'b0;
    case (code)
      `CS_FALL: r = fall;
      `CS_RISE: r = rise;
      `CS_FX:   r = t[0];
      `CS_FX2:  r = t[1];
      // channel 0 taps, channel 1 taps
      `CS_TA:   r = ch ? t[`TAP1_A] : t[`TAP0_A];
      `CS_TB:   r = ch ? t[`TAP1_B] : t[`TAP0_B];
      `CS_TC:   r = ch ? t[`TAP1_C] : t[`TAP0_C];
      `CS_TD:   r = ch ? t[`TAP1_D] : t[`TAP0_D];
      default:  r = 1'b0;
    endcase
    return r;
  endfunction : sel_tick

  // Byte that a write places in a mode-control register
  function automatic logic [7:0] tmc_write(
    input logic [7:0] cur,
    input logic       bit_wr,
    input logic [2:0] sel,
    input logic       val,
    input logic [7:0] wdata
  );
    logic [7:0] v;
    v = cur & `TMC_KEEP;
    if (bit_wr) begin
      v[sel] = val;
    end else begin
      v = wdata;
    end
    return v;
  endfunction : tmc_write

  logic [`NCH-1:0] tcl_hit;
  logic [`NCH-1:0] tmc_hit;
  logic [`NCH-1:0] cmp_hit;
  logic [`NCH-1:0] cnt_hit;
  logic            any_wr;

  always_comb begin
    tcl_hit = {cpu_addr == `A_TCL1, cpu_addr == `A_TCL0};
    tmc_hit = {cpu_addr == `A_TMC1, cpu_addr == `A_TMC0};
    cmp_hit = {cpu_addr == `A_CMP1, cpu_addr == `A_CMP0};
    cnt_hit = {cpu_addr == `A_CNT1, cpu_addr == `A_CNT0};
    any_wr  = cpu_wr | cpu_bit_wr;
  end

  always_comb begin
    logic       run;
    logic       pwm;
    logic       inv;
    logic       gate;
    logic       tick;
    logic       act;
    logic [7:0] nxt;
    logic [7:0] wv;
    s_d        = s_q;
    run        = 1'b0;
    pwm        = 1'b0;
    inv        = 1'b0;
    gate       = 1'b0;
    tick       = 1'b0;
    act        = 1'b0;
    nxt        = `CNT_RST;
    wv         = `TMC_RST;
    s_d.irq    = '0;
    s_d.rd_ack = 1'b0;

    for (int ch = 0; ch < `NCH; ch++) begin
      run  = s_q.tmc[ch][`RUN_BIT];
      pwm  = s_q.tmc[ch][`MODE_BIT];
      inv  = s_q.tmc[ch][`INV_BIT];
      tick = sel_tick(ch[0], s_q.tcl[ch], taps.tick, taps.ev_rise[ch], taps.ev_fall[ch]);
      nxt  = s_q.cnt[ch] + 8'h01;

      if (!run) begin
        s_d.cnt[ch] = `CNT_RST;
        // PWM output falls inactive when stopped
        s_d.pwmff[ch] = 1'b0;
      end else if (tick) begin
        if (!pwm) begin
          // clear and restart on compare match
          if (s_q.cnt[ch] == s_q.cmp[ch]) begin
            s_d.cnt[ch] = `CNT_RST;
            s_d.irq[ch] = 1'b1;
            if (inv) begin
              s_d.outff[ch] = ~s_q.outff[ch];
            end
          end else begin
            s_d.cnt[ch] = nxt;
          end
        end else begin
          s_d.cnt[ch] = nxt;
          // match ends, overflow starts the active phase
          if (nxt == s_q.cmp[ch]) begin
            s_d.pwmff[ch] = 1'b0;
          end else if (s_q.cnt[ch] == `CNT_MAX) begin
            s_d.pwmff[ch] = 1'b1;
          end
        end
      end

      // clock select takes byte writes only
      if (cpu_wr && tcl_hit[ch]) begin
        s_d.tcl[ch] = cpu_wdata[2:0];
      end

      if (cpu_wr && cmp_hit[ch]) begin
        s_d.cmp[ch] = cpu_wdata;
      end

      // bit and byte writes to mode control
      if (any_wr && tmc_hit[ch]) begin
        wv = tmc_write(s_q.tmc[ch], cpu_bit_wr, cpu_bit_sel, cpu_bit_val, cpu_wdata);
        s_d.tmc[ch] = wv & `TMC_KEEP;
        if (!wv[`MODE_BIT]) begin
          // preset codes, 11 leaves the flip-flop alone
          case (wv[`PSET_HI:`PSET_LO])
            `PSET_ZERO: s_d.outff[ch] = 1'b0;
            `PSET_ONE:  s_d.outff[ch] = 1'b1;
            default:    s_d.outff[ch] = s_d.outff[ch];
          endcase
        end
        if (!wv[`RUN_BIT]) begin
          s_d.pwmff[ch] = 1'b0;
        end
      end

      // pin follows the new settings whatever the run bit
      pwm  = s_d.tmc[ch][`MODE_BIT];
      inv  = s_d.tmc[ch][`INV_BIT];
      gate = s_d.tmc[ch][`GATE_BIT];
      act  = s_d.pwmff[ch] & s_d.tmc[ch][`RUN_BIT];
      if (!gate) begin
        s_d.pin[ch] = 1'b0;
      end else if (pwm) begin
        s_d.pin[ch] = inv ? ~act : act;
      end else begin
        s_d.pin[ch] = s_d.outff[ch];
      end
    end

    // Reads answer one cycle later; unmapped addresses read zero
    if (cpu_rd) begin
      s_d.rd_ack = 1'b1;
      s_d.rdata  = `BYTE_ZERO;
      for (int ch = 0; ch < `NCH; ch++) begin
        if (tcl_hit[ch]) begin
          s_d.rdata = {5'h00, s_q.tcl[ch]};
        end
        if (tmc_hit[ch]) begin
          s_d.rdata = s_q.tmc[ch] & `TMC_KEEP;
        end
        if (cmp_hit[ch]) begin
          s_d.rdata = s_q.cmp[ch];
        end
        if (cnt_hit[ch]) begin
          s_d.rdata = s_q.cnt[ch];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // clock select cleared, mode control cleared
      s_q.tcl    <= {`NCH{`TCL_RST}};
      s_q.tmc    <= {`NCH{`TMC_RST}};
      s_q.cnt    <= {`NCH{`CNT_RST}};
      s_q.cmp    <= {`NCH{`CMP_RST}};
      s_q.outff  <= '0;
      s_q.pwmff  <= '0;
      s_q.pin    <= '0;
      s_q.irq    <= '0;
      s_q.rdata  <= `BYTE_ZERO;
      s_q.rd_ack <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cpu_rdata        = s_q.rdata;
  assign cpu_rd_ack       = s_q.rd_ack;
  assign timer_output_pin = s_q.pin;
  assign match_irq        = s_q.irq;

endmodule : eight_bit_timer_control_regs

//--- bench/timer_ctl_monitor.sv
`timescale 1ns/1ps
`include "timer_defines.svh"
module timer_ctl_monitor (
  // Clock and reset
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  // CPU access
  input wire timer_pkg::addr_t cpu_addr,
  input wire logic             cpu_wr,
  input wire timer_pkg::byte_t cpu_wdata,
  input wire logic             cpu_rd,
  input wire timer_pkg::byte_t cpu_rdata,
  input wire logic             cpu_rd_ack,
  // Pins
  input wire timer_pkg::chan_t timer_output_pin,
  input wire timer_pkg::chan_t match_irq
);
  import timer_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire w0 = cpu_wr && cpu_addr == `A_TMC0;
  wire w1 = cpu_wr && cpu_addr == `A_TMC1;
  a_gate_low_ch0: assert property (w0 && !cpu_wdata[0] |=> !timer_output_pin[0])
    else $error("ch0 pin not low");
  a_gate_low_ch1: assert property (w1 && !cpu_wdata[0] |=> !timer_output_pin[1])
    else $error("ch1 pin not low");
  a_preset_sets_pin: assert property (w0 && cpu_wdata[6:2] == 5'h02 && cpu_wdata[0]
    |=> timer_output_pin[0]) else $error("preset high lost");
  a_preset_clears_pin: assert property (w0 && cpu_wdata[6:2] == 5'h01
    |=> !timer_output_pin[0]) else $error("preset low lost");
  a_pwm_idle_level: assert property (w0 && cpu_wdata[7:6] == 2'h1 && cpu_wdata[0]
    |=> timer_output_pin[0] == $past(cpu_wdata[1])) else $error("pwm idle level");
  a_preset_reads_zero: assert property (cpu_rd && cpu_addr inside {`A_TMC0, `A_TMC1}
    |=> cpu_rd_ack && cpu_rdata[3:2] == 2'h0) else $error("preset bits read back");
  a_stop_no_irq: assert property (w0 && !cpu_wdata[7] |=> ##1 !match_irq[0] [*4])
    else $error("irq while stopped");
  a_pwm_no_irq: assert property (w0 && cpu_wdata[7:6] == 2'h3 |=> ##1 !match_irq[0] [*8])
    else $error("irq in pwm");
endmodule : timer_ctl_monitor

bind eight_bit_timer_control_regs timer_ctl_monitor mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
  .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_rd_ack(cpu_rd_ack),
  .timer_output_pin(timer_output_pin), .match_irq(match_irq));

//--- bench/event_source.sv
`timescale 1ns/1ps
module event_source #(
  parameter int HALF = 5
) (
  // Clock and control
  input  wire logic        clk_sys,
  input  wire logic        run_en,
  // Event pins
  output timer_pkg::chan_t event_input_pin
);
  import timer_pkg::*;
  int cnt = 0;
  initial event_input_pin = '0;
  // Pins stand still unless enabled
  always @(posedge clk_sys) begin
    if (run_en) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) event_input_pin <= ~event_input_pin;
    end
  end
endmodule : event_source

//--- bench/eight_bit_timer_control_regs_test.sv
`timescale 1ns/1ps
`include "timer_defines.svh"
module eight_bit_timer_control_regs_test;
  import timer_pkg::*;
  logic  clk_sys = 0, sys_rst = 1, cpu_wr = 0, cpu_bit_wr = 0, cpu_bit_val = 0, cpu_rd = 0;
  logic  cpu_rd_ack, ev_en = 0, tg;
  addr_t cpu_addr = '0, tmc;
  byte_t cpu_wdata = '0, cpu_rdata, d, exp_reg [addr_t];
  bsel_t cpu_bit_sel = '0;
  chan_t event_input_pin, timer_output_pin, match_irq;
  int    error_cnt = 0, checked = 0, cycles = 0, seed = 44, n, t, hi;
  addr_t map [8] = '{`A_TMC0, `A_TMC1, `A_TCL0, `A_TCL1, `A_CNT0, `A_CNT1, `A_CMP0, `A_CMP1};
  int    dv [2][8] = '{'{10, 10, 1, 2, 4, 64, 256, 8192}, '{10, 10, 1, 2, 16, 64, 256, 4096}};
  byte_t seq [4] = '{8'h02, 8'h03, 8'h07, 8'h83};

  eight_bit_timer_control_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_bit_wr(cpu_bit_wr),
    .cpu_bit_sel(cpu_bit_sel), .cpu_bit_val(cpu_bit_val), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .cpu_rd_ack(cpu_rd_ack), .event_input_pin(event_input_pin),
    .timer_output_pin(timer_output_pin), .match_irq(match_irq));
  event_source src (.clk_sys(clk_sys), .run_en(ev_en), .event_input_pin(event_input_pin));

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      stop_test();
    end
  end

  task automatic stop_test;
    $display("Mismatches %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk_byte(input byte_t got, input byte_t exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_int(input int got, input int exp);
    checked++;
    if (got != exp) begin
      error_cnt++;
      $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_int

  task automatic wr(input addr_t a, input byte_t v);
    @(posedge clk_sys);
    cpu_addr  <= a;
    cpu_wdata <= v;
    cpu_wr    <= 1'b1;
    @(posedge clk_sys);
    cpu_wr <= 1'b0;
    if (a == `A_TMC0 || a == `A_TMC1) exp_reg[a] = v & `TMC_KEEP;
    else if (a == `A_TCL0 || a == `A_TCL1) exp_reg[a] = v & 8'h07;
    else if (a == `A_CMP0 || a == `A_CMP1) exp_reg[a] = v;
  endtask : wr

  task automatic bw(input addr_t a, input bsel_t s, input logic v);
    @(posedge clk_sys);
    cpu_addr    <= a;
    cpu_bit_sel <= s;
    cpu_bit_val <= v;
    cpu_bit_wr  <= 1'b1;
    @(posedge clk_sys);
    cpu_bit_wr <= 1'b0;
    if (a == `A_TMC1 && `TMC_KEEP >> s & 1) exp_reg[a][s] = v;
  endtask : bw

  task automatic rd_chk(input addr_t a);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_rd   <= 1'b1;
    @(posedge clk_sys);
    cpu_rd <= 1'b0;
    @(posedge clk_sys);
    chk_byte({7'h00, cpu_rd_ack}, 8'h01);
    chk_byte(cpu_rdata, exp_reg.exists(a) ? exp_reg[a] : 8'h00);
  endtask : rd_chk

  task automatic period(input int ch, output int p, output logic tog);
    int   k;
    logic pin0;
    k = 0;
    while (match_irq[ch] !== 1'b1 && k < 20000) begin
      @(posedge clk_sys);
      k++;
    end
    pin0 = timer_output_pin[ch];
    p = 0;
    do begin
      @(posedge clk_sys);
      p++;
    end while (match_irq[ch] !== 1'b1 && p < 20000);
    // Pin must have flipped exactly once between two matches
    tog = pin0 ^ timer_output_pin[ch];
  endtask : period

  initial begin
    foreach (map[i]) exp_reg[map[i]] = 8'h00;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (map[i]) rd_chk(map[i]);
    wr(16'h0000, 8'hFF);
    rd_chk(16'h0000);
    repeat (4) begin
      d = $random(seed);
      d[7] = 1'b0;
      d[2] = d[2] & ~d[3];
      foreach (map[i]) wr(map[i], map[i] inside {`A_TCL0, `A_TCL1} ? d & 8'h07 : d);
      foreach (map[i]) rd_chk(map[i]);
    end
    for (int b = 0; b < 8; b++) begin
      bw(`A_TCL1, b[2:0], 1'b1);
      bw(`A_TMC1, b[2:0], ~exp_reg[`A_TMC1][b]);
    end
    rd_chk(`A_TCL1);
    rd_chk(`A_TMC1);
    ev_en <= 1'b1;
    for (int ch = 0; ch < 2; ch++) begin
      tmc = ch ? `A_TMC1 : `A_TMC0;
      for (int c = 0; c < 8; c++) begin
        n = (c < 6) ? 2 : 0;
        wr(tmc, 8'h00);
        wr(ch ? `A_TCL1 : `A_TCL0, c[7:0]);
        wr(ch ? `A_CMP1 : `A_CMP0, n[7:0]);
        foreach (seq[j]) wr(tmc, (c[0] && j == 2) ? 8'h0B : seq[j]);
        period(ch, t, tg);
        chk_int(t, (n + 1) * dv[ch][c]);
        chk_byte({7'h00, tg}, 8'h01);
      end
    end
    ev_en <= 1'b0;
    wr(`A_TMC0, 8'h00);
    wr(`A_TCL0, 8'h02);
    n = 8'h40 + ($random(seed) & 8'h3F);
    wr(`A_CMP0, n[7:0]);
    for (int inv = 0; inv < 2; inv++) begin
      wr(`A_TMC0, 8'h40 | inv << 1);
      wr(`A_TMC0, 8'h41 | inv << 1);
      wr(`A_TMC0, 8'hC1 | inv << 1);
      repeat (300) @(posedge clk_sys);
      hi = 0;
      repeat (256) begin
        @(posedge clk_sys);
        hi += timer_output_pin[0];
      end
      chk_int(hi, inv ? 256 - n : n);
    end
    wr(`A_TMC0, 8'h41);
    wr(`A_TMC0, 8'h01);
    wr(`A_TMC0, 8'h05);
    wr(`A_TMC0, 8'h41);
    wr(`A_TMC0, 8'h49);
    @(posedge clk_sys);
    chk_byte({7'h00, timer_output_pin[0]}, 8'h00);
    // Back out of PWM: the flip-flop must still hold the earlier low preset
    wr(`A_TMC0, 8'h01);
    @(posedge clk_sys);
    chk_byte({7'h00, timer_output_pin[0]}, 8'h00);
    stop_test();
  end
endmodule : eight_bit_timer_control_regs_test
